// ===== rtl/dspf_pkg.sv
// constants, carrier types and the header code shared by the framer
// assumes one system clock domain plus a separate link clock at the top
package dspf_pkg;
   // data type codes
   localparam logic [5:0] DT_PIX18L = 6'h2E;
   localparam logic [5:0] DT_PIX24 = 6'h3E;
   localparam logic [5:0] DT_ACK_ERR = 6'h02;
   localparam logic [5:0] DT_RD_SHORT = 6'h21;
   localparam logic [5:0] DT_RD_LONG = 6'h1A;
   // trigger bytes, bit 0 leaves first
   localparam logic [7:0] TRIG_ACK = 8'h84;
   localparam logic [7:0] TRIG_TE = 8'h5D;
   localparam logic [3:0] NIB_LOW = 4'h0;
   localparam logic [3:0] NIB_HIGH = 4'hF;
   // frame sizes in bytes
   localparam logic [2:0] HDR_LAST = 3'h3;
   localparam logic [15:0] FOOT_LEN = 16'h0002;
   localparam logic [15:0] RD_LONG_WC = 16'h0002;
   localparam logic [3:0] LEN_TRIG = 4'h1;
   localparam logic [3:0] LEN_SHORT = 4'h4;
   localparam logic [3:0] LEN_LONG = 4'h8;
   localparam int RF_MAX = 8;
   // accumulated error flags
   localparam int ERR_W = 3;
   localparam int ERR_ECC1 = 0;
   localparam int ERR_ECCM = 1;
   localparam int ERR_DT = 2;

   typedef struct packed {logic [7:0] r; logic [7:0] g; logic [7:0] b;} dspf_pix_t;
   typedef struct packed {logic [1:0] vc; logic [5:0] dt; logic [15:0] wc;} dspf_hdr_t;
   typedef struct packed {logic [RF_MAX-1:0][7:0] byt; logic [3:0] len;} dspf_rframe_t;
   typedef enum logic [1:0] {P_IDLE = 2'b00, P_HDR = 2'b01, P_PAY = 2'b10, P_FOOT = 2'b11} dspf_pst_t;
   typedef enum logic [2:0] {R_IDLE = 3'b000, R_HDR = 3'b001, R_PAY = 3'b010, R_FOOT = 3'b011,
      R_DROP = 3'b100} dspf_rxst_t;
   typedef enum logic [1:0] {L_IDLE = 2'b00, L_SHIFT = 2'b01, L_TURN = 2'b10} dspf_lst_t;

   // position code of header data bit k: the k-th number from 3 that is not a power of two
   function automatic logic [4:0] dspf_code(input int k);
      int n;
      logic [4:0] r;
      n = 0;
      r = 5'h00;
      for (int c = 3; c < 32; c++) begin
         if (((c & (c - 1)) != 0) && n <= k) begin
            r = 5'(c);
            n++;
         end
      end
      return r;
   endfunction

   // single-error-correcting check byte over the 24 header bits
   function automatic logic [7:0] dspf_ecc(input logic [23:0] d);
      logic [4:0] p;
      p = 5'h00;
      for (int k = 0; k < 24; k++) begin
         if (d[k]) p = p ^ dspf_code(k);
      end
      return {3'h0, p};
   endfunction
endpackage

// ===== rtl/dspf_framer.sv
// pixel packer, forward unpacker and reverse low-power transmitter of the display link
// assumes forward bytes and turnaround grants arrive on clk; link_clk runs during reverse sends
`timescale 1ns/100ps
module dspf_framer import dspf_pkg::*; #(
   parameter int LANES = 4
) (
   // clocks and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   // settings
   input wire logic ecc_chk_en,
   // packet request and pixels to pack
   input wire logic pkt_valid,
   output logic pkt_ready,
   input wire dspf_hdr_t pkt_hdr,
   input wire logic pix_valid,
   output logic pix_ready,
   input wire dspf_pix_t pix,
   // packed byte stream
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_last,
   // forward bytes from the lane receiver
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_end,
   // unpacked headers and pixels
   output logic rx_hdr_valid,
   output dspf_hdr_t rx_hdr,
   output logic rx_pix_valid,
   output dspf_pix_t rx_pix,
   // reverse requests
   input wire logic bta_in,
   input wire logic rd_valid,
   output logic rd_ready,
   input wire logic rd_long,
   input wire logic [15:0] rd_data,
   input wire logic te_req,
   output logic rev_busy,
   // lane side, link clock
   output logic [LANES-1:0] lane_oe,
   output logic lane0_dout,
   output logic lp_active,
   output logic turn_pulse
);
   if (LANES < 1 || LANES > 4) begin : g_bad_lanes
      $error("LANES must be 1 to 4");
   end

   // ---------------- packer ----------------
   dspf_pst_t pst_r, pst_nxt;
   dspf_hdr_t phdr_r, phdr_nxt;
   dspf_pix_t ppix_r, ppix_nxt;
   logic have_r, have_nxt;
   logic [1:0] psub_r, psub_nxt;
   logic [15:0] pcnt_r, pcnt_nxt;
   logic [7:0] hbyte;
   logic fmt24;

   assign fmt24 = (phdr_r.dt == DT_PIX24);
   assign pkt_ready = (pst_r == P_IDLE);
   assign pix_ready = (pst_r == P_PAY) && !have_r;
   assign tx_valid = (pst_r == P_HDR) || (pst_r == P_FOOT) || (pst_r == P_PAY && have_r);
   assign tx_last = (pst_r == P_FOOT) && (pcnt_r == 16'h0001);

   // header bytes in order id, count low, count high, check
   always_comb begin
      unique case (psub_r)
         2'h0: hbyte = {phdr_r.vc, phdr_r.dt};
         2'h1: hbyte = phdr_r.wc[7:0];
         2'h2: hbyte = phdr_r.wc[15:8];
         2'h3: hbyte = dspf_ecc({phdr_r.wc, phdr_r.vc, phdr_r.dt});
      endcase
   end

   // byte mux, all sources registered
   always_comb begin
      tx_data = 8'h00;
      if (pst_r == P_HDR) begin
         tx_data = hbyte;
      end else if (pst_r == P_PAY) begin
         unique case (psub_r)
            2'h0: tx_data = fmt24 ? ppix_r.r : {ppix_r.r[5:0], 2'h0};
            2'h1: tx_data = fmt24 ? ppix_r.g : {ppix_r.g[5:0], 2'h0};
            default: tx_data = fmt24 ? ppix_r.b : {ppix_r.b[5:0], 2'h0};
         endcase
      end
   end

   // only the two pixel types are ever framed; anything else is refused at the request
   always_comb begin
      pst_nxt = pst_r;
      phdr_nxt = phdr_r;
      ppix_nxt = ppix_r;
      have_nxt = have_r;
      psub_nxt = psub_r;
      pcnt_nxt = pcnt_r;
      unique case (pst_r)
         P_IDLE: begin
            if (pkt_valid && (pkt_hdr.dt == DT_PIX18L || pkt_hdr.dt == DT_PIX24)) begin
               phdr_nxt = pkt_hdr;
               psub_nxt = 2'h0;
               pst_nxt = P_HDR;
            end
         end
         P_HDR: begin
            if (tx_ready) begin
               psub_nxt = psub_r + 2'h1;
               if (psub_r == HDR_LAST[1:0]) begin
                  psub_nxt = 2'h0;
                  pcnt_nxt = phdr_r.wc;
                  have_nxt = 1'b0;
                  pst_nxt = (phdr_r.wc == 16'h0000) ? P_FOOT : P_PAY;
                  if (phdr_r.wc == 16'h0000) pcnt_nxt = FOOT_LEN;
               end
            end
         end
         P_PAY: begin
            if (!have_r && pix_valid) begin
               ppix_nxt = pix;
               have_nxt = 1'b1;
               psub_nxt = 2'h0;
            end else if (have_r && tx_ready) begin
               psub_nxt = psub_r + 2'h1;
               pcnt_nxt = pcnt_r - 16'h0001;
               if (psub_r == 2'h2) have_nxt = 1'b0;
               if (pcnt_r == 16'h0001) begin // count not a multiple of three truncates the pixel
                  have_nxt = 1'b0;
                  pcnt_nxt = FOOT_LEN;
                  pst_nxt = P_FOOT;
               end
            end
         end
         P_FOOT: begin
            if (tx_ready) begin
               pcnt_nxt = pcnt_r - 16'h0001;
               if (pcnt_r == 16'h0001) pst_nxt = P_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pst_r <= P_IDLE;
         phdr_r <= '0;
         ppix_r <= '0;
         have_r <= 1'b0;
         psub_r <= 2'h0;
         pcnt_r <= 16'h0000;
      end else begin
         pst_r <= pst_nxt;
         phdr_r <= phdr_nxt;
         ppix_r <= ppix_nxt;
         have_r <= have_nxt;
         psub_r <= psub_nxt;
         pcnt_r <= pcnt_nxt;
      end
   end

   // ---------------- forward receiver ----------------
   dspf_rxst_t rst_r, rst_nxt;
   logic [2:0][7:0] hb_r, hb_nxt;
   logic [1:0] rsub_r, rsub_nxt;
   logic [15:0] rcnt_r, rcnt_nxt;
   logic [1:0][7:0] pb_r, pb_nxt;
   logic r24_r, r24_nxt;
   logic hv_r, hv_nxt, pv_r, pv_nxt;
   dspf_hdr_t rh_r, rh_nxt;
   dspf_pix_t rp_r, rp_nxt;
   logic [ERR_W-1:0] err_set;
   logic [7:0] hecc;
   logic [4:0] syn;
   logic [23:0] fixm, dfix;
   logic e_one, e_multi, flat0;

   // syndrome and correction mask for the header ending with this byte
   always_comb begin
      hecc = dspf_ecc({hb_r[2], hb_r[1], hb_r[0]});
      syn = hecc[4:0] ^ rx_data[4:0];
      fixm = 24'h000000;
      for (int k = 0; k < 24; k++) begin
         if (dspf_code(k) == syn) fixm[k] = 1'b1;
      end
      e_one = ecc_chk_en && (syn != 5'h00) && ((fixm != 24'h000000) || ((syn & (syn - 5'h01)) == 5'h00));
      e_multi = ecc_chk_en && (syn != 5'h00) && !e_one;
      dfix = {hb_r[2], hb_r[1], hb_r[0]} ^ (ecc_chk_en ? fixm : 24'h000000);
   end

   assign flat0 = (rx_data[3:0] == NIB_LOW) || (rx_data[3:0] == NIB_HIGH);

   always_comb begin
      rst_nxt = rst_r;
      hb_nxt = hb_r;
      rsub_nxt = rsub_r;
      rcnt_nxt = rcnt_r;
      pb_nxt = pb_r;
      r24_nxt = r24_r;
      hv_nxt = 1'b0;
      pv_nxt = 1'b0;
      rh_nxt = rh_r;
      rp_nxt = rp_r;
      err_set = '0;
      if (rx_end) begin
         rst_nxt = R_IDLE;
      end else if (rx_valid) begin
         unique case (rst_r)
            R_IDLE: begin
               if (!flat0) begin
                  hb_nxt[0] = rx_data;
                  rsub_nxt = 2'h1;
                  rst_nxt = R_HDR;
               end
            end
            R_HDR: begin
               if (rsub_r != HDR_LAST[1:0]) begin
                  hb_nxt[rsub_r] = rx_data;
                  rsub_nxt = rsub_r + 2'h1;
               end else begin
                  rh_nxt = {dfix[7:6], dfix[5:0], dfix[23:8]};
                  err_set[ERR_ECC1] = e_one;
                  err_set[ERR_ECCM] = e_multi;
                  rst_nxt = R_IDLE;
                  if (e_multi) begin
                     rst_nxt = R_DROP; // rest of the transmission is unusable
                  end else if (dfix[3:0] == NIB_LOW || dfix[3:0] == NIB_HIGH) begin
                     err_set[ERR_DT] = 1'b1;
                     rst_nxt = R_DROP;
                  end else begin
                     hv_nxt = 1'b1;
                     if (dfix[5:0] == DT_PIX18L || dfix[5:0] == DT_PIX24) begin
                        r24_nxt = (dfix[5:0] == DT_PIX24);
                        rsub_nxt = 2'h0;
                        rcnt_nxt = (dfix[23:8] == 16'h0000) ? FOOT_LEN : dfix[23:8];
                        rst_nxt = (dfix[23:8] == 16'h0000) ? R_FOOT : R_PAY;
                     end
                  end
               end
            end
            R_PAY: begin
               rsub_nxt = (rsub_r == 2'h2) ? 2'h0 : rsub_r + 2'h1;
               rcnt_nxt = rcnt_r - 16'h0001;
               if (rsub_r != 2'h2) begin
                  pb_nxt[rsub_r[0]] = rx_data;
               end else begin
                  pv_nxt = 1'b1;
                  rp_nxt.r = r24_r ? pb_r[0] : {2'h0, pb_r[0][7:2]};
                  rp_nxt.g = r24_r ? pb_r[1] : {2'h0, pb_r[1][7:2]};
                  rp_nxt.b = r24_r ? rx_data : {2'h0, rx_data[7:2]};
               end
               if (rcnt_r == 16'h0001) begin
                  rcnt_nxt = FOOT_LEN;
                  rst_nxt = R_FOOT;
               end
            end
            R_FOOT: begin
               // checksum is not checked here
               rcnt_nxt = rcnt_r - 16'h0001;
               if (rcnt_r == 16'h0001) rst_nxt = R_IDLE;
            end
            default: rst_nxt = R_DROP;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rst_r <= R_IDLE;
         hb_r <= '0;
         rsub_r <= 2'h0;
         rcnt_r <= 16'h0000;
         pb_r <= '0;
         r24_r <= 1'b0;
         hv_r <= 1'b0;
         pv_r <= 1'b0;
         rh_r <= '0;
         rp_r <= '0;
      end else begin
         rst_r <= rst_nxt;
         hb_r <= hb_nxt;
         rsub_r <= rsub_nxt;
         rcnt_r <= rcnt_nxt;
         pb_r <= pb_nxt;
         r24_r <= r24_nxt;
         hv_r <= hv_nxt;
         pv_r <= pv_nxt;
         rh_r <= rh_nxt;
         rp_r <= rp_nxt;
      end
   end

   assign rx_hdr_valid = hv_r;
   assign rx_hdr = rh_r;
   assign rx_pix_valid = pv_r;
   assign rx_pix = rp_r;

   // ---------------- reverse response builder ----------------
   logic [ERR_W-1:0] err_r, err_nxt;
   logic bta_r, bta_nxt, rdp_r, rdp_nxt, rdl_r, rdl_nxt, tep_r, tep_nxt;
   logic [15:0] rdd_r, rdd_nxt;
   logic busy_r, busy_nxt, req_r, req_nxt;
   dspf_rframe_t rf_r, rf_nxt;
   logic dn1, dn2, dn3, done;
   logic lt_done_r; // toggled by the link side when a send is over
   logic launch, rep;

   assign launch = bta_r && !busy_r;
   assign rep = launch && (err_r != '0);
   assign done = dn2 ^ dn3;
   assign rd_ready = !rdp_r;
   assign rev_busy = busy_r;

   always_comb begin
      err_nxt = err_r | err_set;
      bta_nxt = bta_r | bta_in;
      rdp_nxt = rdp_r;
      rdl_nxt = rdl_r;
      rdd_nxt = rdd_r;
      tep_nxt = tep_r | te_req;
      busy_nxt = busy_r && !done;
      req_nxt = req_r;
      rf_nxt = rf_r;
      if (rd_valid && !rdp_r) begin
         rdp_nxt = 1'b1;
         rdl_nxt = rd_long;
         rdd_nxt = rd_data;
      end
      if (launch) begin
         bta_nxt = bta_in;
         busy_nxt = 1'b1;
         req_nxt = !req_r;
         rf_nxt = '0;
         if (err_r != '0) begin
            rf_nxt.byt[0] = {2'h0, DT_ACK_ERR};
            rf_nxt.byt[1] = {{(8 - ERR_W){1'b0}}, err_r};
            rf_nxt.byt[3] = dspf_ecc({8'h00, {(8 - ERR_W){1'b0}}, err_r, 2'h0, DT_ACK_ERR});
            rf_nxt.len = LEN_SHORT;
            err_nxt = err_set;
            if (rdp_r) rdp_nxt = 1'b0; // a read already pending is cleared here and never sent
         end else if (rdp_r && rdl_r) begin
            rf_nxt.byt[0] = {2'h0, DT_RD_LONG};
            rf_nxt.byt[1] = RD_LONG_WC[7:0];
            rf_nxt.byt[2] = RD_LONG_WC[15:8];
            rf_nxt.byt[3] = dspf_ecc({RD_LONG_WC, 2'h0, DT_RD_LONG});
            rf_nxt.byt[4] = rdd_r[7:0];
            rf_nxt.byt[5] = rdd_r[15:8];
            rf_nxt.len = LEN_LONG;
            rdp_nxt = 1'b0;
         end else if (rdp_r) begin
            rf_nxt.byt[0] = {2'h0, DT_RD_SHORT};
            rf_nxt.byt[1] = rdd_r[7:0];
            rf_nxt.byt[2] = rdd_r[15:8];
            rf_nxt.byt[3] = dspf_ecc({rdd_r, 2'h0, DT_RD_SHORT});
            rf_nxt.len = LEN_SHORT;
            rdp_nxt = 1'b0;
         end else if (tep_r) begin
            rf_nxt.byt[0] = TRIG_TE;
            rf_nxt.len = LEN_TRIG;
            tep_nxt = te_req;
         end else begin
            rf_nxt.byt[0] = TRIG_ACK;
            rf_nxt.len = LEN_TRIG;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         err_r <= '0;
         bta_r <= 1'b0;
         rdp_r <= 1'b0;
         rdl_r <= 1'b0;
         rdd_r <= 16'h0000;
         tep_r <= 1'b0;
         busy_r <= 1'b0;
         req_r <= 1'b0;
         rf_r <= '0;
         {dn1, dn2, dn3} <= 3'h0;
      end else begin
         err_r <= err_nxt;
         bta_r <= bta_nxt;
         rdp_r <= rdp_nxt;
         rdl_r <= rdl_nxt;
         rdd_r <= rdd_nxt;
         tep_r <= tep_nxt;
         busy_r <= busy_nxt;
         req_r <= req_nxt;
         rf_r <= rf_nxt;
         {dn1, dn2, dn3} <= {lt_done_r, dn1, dn2};
      end
   end

   // ---------------- link domain serialiser ----------------
   // frame words stay frozen while busy, so the toggle handshake makes them safe to read here
   logic lrs1, lrs2, rq1, rq2, rq3;
   dspf_lst_t lst_r, lst_nxt;
   logic [5:0] lbit_r, lbit_nxt;
   logic ldout_r, ldout_nxt, loe_r, loe_nxt, lturn_r, lturn_nxt, lt_done_nxt;

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         {lrs1, lrs2} <= 2'h3;
      end else begin
         {lrs1, lrs2} <= {1'b0, lrs1};
      end
   end

   always_comb begin
      lst_nxt = lst_r;
      lbit_nxt = lbit_r;
      ldout_nxt = 1'b0;
      loe_nxt = 1'b0;
      lturn_nxt = 1'b0;
      lt_done_nxt = lt_done_r;
      unique case (lst_r)
         L_IDLE: begin
            if (rq2 ^ rq3) begin
               lbit_nxt = 6'h00;
               lst_nxt = L_SHIFT;
            end
         end
         L_SHIFT: begin
            loe_nxt = 1'b1;
            ldout_nxt = rf_r.byt[lbit_r[5:3]][lbit_r[2:0]];
            lbit_nxt = lbit_r + 6'h01;
            if (lbit_r == {rf_r.len[2:0] - 3'h1, 3'h7}) lst_nxt = L_TURN;
         end
         L_TURN: begin
            lturn_nxt = 1'b1;
            lt_done_nxt = !lt_done_r;
            lst_nxt = L_IDLE;
         end
         default: lst_nxt = L_IDLE;
      endcase
   end

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         {rq1, rq2, rq3} <= 3'h0;
         lst_r <= L_IDLE;
         lbit_r <= 6'h00;
         ldout_r <= 1'b0;
         loe_r <= 1'b0;
         lturn_r <= 1'b0;
         lt_done_r <= 1'b0;
      end else if (lrs2) begin
         {rq1, rq2, rq3} <= 3'h0;
         lst_r <= L_IDLE;
         lbit_r <= 6'h00;
         ldout_r <= 1'b0;
         loe_r <= 1'b0;
         lturn_r <= 1'b0;
         lt_done_r <= 1'b0;
      end else begin
         {rq1, rq2, rq3} <= {req_r, rq1, rq2};
         lst_r <= lst_nxt;
         lbit_r <= lbit_nxt;
         ldout_r <= ldout_nxt;
         loe_r <= loe_nxt;
         lturn_r <= lturn_nxt;
         lt_done_r <= lt_done_nxt;
      end
   end

   // only lane 0 ever turns round; the others stay forward
   assign lane_oe = LANES'(loe_r);
   assign lane0_dout = ldout_r;
   assign lp_active = loe_r;
   assign turn_pulse = lturn_r;

   // ---------------- assertions ----------------
   property p_dt_legal;
      @(posedge clk) disable iff (rst) (pst_r == P_HDR && psub_r == 2'h0) |->
         (tx_data[5:0] == DT_PIX18L || tx_data[5:0] == DT_PIX24);
   endproperty
   a_dt_legal: assert property (p_dt_legal) else $error("illegal data type framed");

   property p_pack18;
      @(posedge clk) disable iff (rst) (pst_r == P_PAY && tx_valid && !fmt24) |-> tx_data[1:0] == 2'h0;
   endproperty
   a_pack18: assert property (p_pack18) else $error("18-bit byte low bits not zero");

   property p_foot_zero;
      @(posedge clk) disable iff (rst) (pst_r == P_FOOT) |-> (tx_valid && tx_data == 8'h00);
   endproperty
   a_foot_zero: assert property (p_foot_zero) else $error("footer not zero");

   property p_hold;
      @(posedge clk) disable iff (rst) (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data));
   endproperty
   a_hold: assert property (p_hold) else $error("byte changed while stalled");

   property p_ack_clean;
      @(posedge clk) disable iff (rst) (launch && err_r != '0) |=> (rf_r.byt[0] != TRIG_ACK);
   endproperty
   a_ack_clean: assert property (p_ack_clean) else $error("ack sent with errors pending");

   property p_err_clear;
      @(posedge clk) disable iff (rst) (rep && err_set == '0) |=> (err_r == '0 && rf_r.len == LEN_SHORT);
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("reported errors not cleared");

   property p_eot;
      @(posedge clk) disable iff (rst) (rst_r == R_IDLE && rx_valid && !rx_end && flat0) |=> rst_r == R_IDLE;
   endproperty
   a_eot: assert property (p_eot) else $error("flat nibble opened a packet");

   property p_multi_drop;
      @(posedge clk) disable iff (rst) (rst_r == R_HDR && rx_valid && !rx_end && rsub_r == 2'h3 && e_multi)
         |=> (rst_r == R_DROP && err_r[ERR_ECCM]);
   endproperty
   a_multi_drop: assert property (p_multi_drop) else $error("multi-bit header not dropped");

   property p_turn;
      @(posedge link_clk) disable iff (lrs2) (lst_r == L_SHIFT && lst_nxt == L_TURN) |-> ##2 turn_pulse;
   endproperty
   a_turn: assert property (p_turn) else $error("no turnaround after send");

   property p_lp_only;
      @(posedge link_clk) disable iff (lrs2) lp_active |-> $past(lst_r) == L_SHIFT;
   endproperty
   a_lp_only: assert property (p_lp_only) else $error("lane driven outside a send");
endmodule // dspf_framer

// ===== sim/dspf_host_model.sv
// host end of the reverse lane: gathers the bytes the framer sends back
// assumes bits leave on rising link_clk, lane 0 only
`timescale 1ns/100ps
module dspf_host_model #(
   parameter int LANES = 4
) (
   // lane side of the framer
   input wire logic link_clk,
   input wire logic [LANES-1:0] lane_oe,
   input wire logic lane0_dout,
   input wire logic lp_active,
   input wire logic turn_pulse
);
   logic [7:0] rq[$];
   logic [7:0] sh = 8'h00;
   int nb = 0;
   int turn_cnt = 0;
   logic side_lane = 1'h0;
   logic hs_seen = 1'h0;
   // sample mid-bit so launch-edge updates never race the capture
   always @(negedge link_clk) begin
      if (lane_oe[0]) begin
         sh = {lane0_dout, sh[7:1]};
         nb++;
         if (nb % 8 == 0) rq.push_back(sh);
      end else nb = 0;
      if (|lane_oe[LANES-1:1]) side_lane = 1'h1;
      if (lp_active !== lane_oe[0]) hs_seen = 1'h1;
      if (turn_pulse) turn_cnt++;
   end
endmodule // dspf_host_model

// ===== sim/tb_top.sv
// bench for the framer: packing, unpacking and reverse sends
// assumes the host model on the lane collects the reverse bytes
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; $display("Error %0t: %h vs %h", $time, a, e); end end
module tb_top import dspf_pkg::*;;
   logic clk = 0, rst = 1, link_clk = 0, ecc_chk_en = 0, pkt_valid = 0, pix_valid = 0, tx_ready = 1;
   logic rx_valid = 0, rx_end = 0, bta_in = 0, rd_valid = 0, rd_long = 0, te_req = 0;
   logic [7:0] rx_data = 8'h00;
   logic [15:0] rd_data = 16'h0000;
   dspf_hdr_t pkt_hdr = '0;
   dspf_pix_t pix = '0;
   logic pkt_ready, pix_ready, tx_valid, tx_last, rx_hdr_valid, rx_pix_valid, rd_ready, rev_busy;
   logic lp_active, turn_pulse, lane0_dout;
   logic [7:0] tx_data;
   logic [3:0] lane_oe;
   dspf_hdr_t rx_hdr;
   dspf_pix_t rx_pix;
   int error_cnt = 0, n_tests = 0, hdr_cnt = 0, pix_cnt = 0;
   dspf_framer #(.LANES(4)) u_dut (.clk, .rst, .link_clk, .ecc_chk_en, .pkt_valid, .pkt_ready, .pkt_hdr,
      .pix_valid, .pix_ready, .pix, .tx_valid, .tx_ready, .tx_data, .tx_last, .rx_valid, .rx_data, .rx_end,
      .rx_hdr_valid, .rx_hdr, .rx_pix_valid, .rx_pix, .bta_in, .rd_valid, .rd_ready, .rd_long, .rd_data,
      .te_req, .rev_busy, .lane_oe, .lane0_dout, .lp_active, .turn_pulse);
   dspf_host_model #(.LANES(4)) u_host (.link_clk, .lane_oe, .lane0_dout, .lp_active, .turn_pulse);
   always #4 clk = ~clk;
   // link clock offset so its edges never line up with clk
   initial begin
      #3;
      forever #32 link_clk = ~link_clk;
   end
   always @(posedge clk) begin
      if (rx_hdr_valid) hdr_cnt++;
      if (rx_pix_valid) pix_cnt++;
   end
   task automatic print_verdict();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one-pixel packet; one stall shows a byte stands until taken
   task automatic pack_test(input logic [5:0] dt, input dspf_pix_t p, input logic [23:0] e, input logic [7:0] c);
      logic [7:0] q[9] = '{{2'h0, dt}, 8'h03, 8'h00, c, e[23:16], e[15:8], e[7:0], 8'h00, 8'h00};
      logic took = 1'h0;
      logic st = 1'h0;
      int i = 0;
      @(negedge clk);
      pkt_hdr = {2'h0, dt, 16'h0003};
      pkt_valid = 1'h1;
      pix = p;
      pix_valid = 1'h1;
      for (int k = 0; i < 9 && k < 200; k++) begin
         @(negedge clk);
         pkt_valid = 1'h0;
         if (took) pix_valid = 1'h0;
         took = pix_ready & pix_valid;
         tx_ready = !(i == 5 && !st);
         st = st | (i == 5);
         if (tx_valid && tx_ready) begin
            `CHK(tx_data, q[i])
            `CHK(tx_last, i == 8)
            i++;
         end
      end
      `CHK(i, 9)
      $display("pack %h done", dt);
   endtask
   task automatic rej_test();
      logic [5:0] c[3] = '{6'h10, 6'h2F, 6'h05};
      foreach (c[j]) begin
         @(negedge clk);
         pkt_hdr = {2'h0, c[j], 16'h0003};
         pkt_valid = 1'h1;
         repeat (4) @(negedge clk);
         pkt_valid = 1'h0;
         `CHK({tx_valid, pkt_ready}, 2'h1)
      end
      $display("reject done");
   endtask
   task automatic rx_send(input logic [7:0] b[$]);
      foreach (b[j]) begin
         @(negedge clk);
         rx_valid = 1'h1;
         rx_data = b[j];
      end
      @(negedge clk);
      rx_valid = 1'h0;
      rx_data = ~rx_data; // released data must not look held
      rx_end = 1'h1;
      @(negedge clk);
      rx_end = 1'h0;
   endtask
   task automatic rev_test(input logic [7:0] e0, e1, e2, input int n);
      int t = u_host.turn_cnt;
      u_host.rq.delete();
      @(negedge clk);
      bta_in = 1'h1;
      @(negedge clk);
      bta_in = 1'h0;
      for (int k = 0; k < 2000 && (rev_busy || k < 2); k++) @(negedge clk);
      repeat (2) @(negedge link_clk); // busy drops before the host model logs the turnaround
      `CHK(u_host.rq.size(), n)
      `CHK(u_host.rq[0], e0)
      if (n > 1) `CHK({u_host.rq[1], u_host.rq[2]}, {e1, e2})
      `CHK(u_host.turn_cnt, t + 1)
      `CHK({u_host.side_lane, u_host.hs_seen}, 2'h0)
      $display("reverse %h done", e0);
   endtask
   task automatic rd_req(input logic l);
      @(negedge clk);
      rd_valid = 1'h1;
      rd_long = l;
      rd_data = 16'hBEEF;
      @(negedge clk);
      rd_valid = 1'h0;
      `CHK(rd_ready, 1'h0)
   endtask
   initial begin
      repeat (3) @(negedge link_clk);
      @(negedge clk);
      rst = 1'h0;
      repeat (12) @(negedge clk);
      pack_test(6'h2E, {8'h2D, 8'h12, 8'h3F}, 24'hB448FC, 8'h0D);
      pack_test(6'h3E, {8'hA5, 8'h3C, 8'h81}, 24'hA53C81, 8'h04);
      rej_test();
      rx_send('{8'h0F, 8'h2E, 8'h03, 8'h00, 8'h00, 8'hB7, 8'h4A, 8'hFE, 8'h00, 8'h00});
      `CHK({rx_hdr, rx_pix}, {24'h2E0003, 24'h2D123F})
      `CHK({hdr_cnt, pix_cnt}, {32'h1, 32'h1})
      rev_test(8'h84, 8'h00, 8'h00, 1);
      @(negedge clk);
      te_req = 1'h1;
      @(negedge clk);
      te_req = 1'h0;
      rev_test(8'h5D, 8'h00, 8'h00, 1);
      rd_req(1'h0);
      rev_test(8'h21, 8'hEF, 8'hBE, 4);
      rd_req(1'h1);
      rev_test(8'h1A, 8'h02, 8'h00, 8);
      `CHK({u_host.rq[4], u_host.rq[5], u_host.rq[6], u_host.rq[7]}, 32'hEFBE0000)
      ecc_chk_en = 1'h1;
      // header with one id bit flipped is mended, used and reported
      rx_send('{8'h07, 8'h00, 8'h00, 8'h05});
      `CHK(rx_hdr, 24'h050000)
      rev_test(8'h02, 8'h01, 8'h00, 4);
      // header whose check byte is off in several bits
      rx_send('{8'h01, 8'h00, 8'h00, 8'h1D});
      rev_test(8'h02, 8'h02, 8'h00, 4);
      rev_test(8'h84, 8'h00, 8'h00, 1);
      print_verdict();
   end
   // cut a hang short far beyond the expected few thousand clocks
   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end
endmodule // tb_top
